// *** hw/cocr_top.sv ***
// Clock output control bank with its serial block-write slave
`timescale 1ns/1ps
`include "cocr_regs.svh"
module cocr_top (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                resetn,
  // Serial bus, data pin open drain
  input  wire cocr_pkg::cocr_smb_s smb_in,
  output logic                     sda_out,
  output logic                     sda_oe,
  // Control pins
  input  wire logic                power_down_n,
  input  wire logic                cpu_stop_n,
  input  wire logic                slot_stop_n,
  input  wire logic                mid5_is_output,
  // Source clocks
  input  wire logic                cpu_src,
  input  wire logic                slot_src,
  input  wire logic                mid_src,
  input  wire logic                mid_in_src,
  input  wire logic                usb_src,
  // Processor pairs 2..0
  output cocr_pkg::cocr_pair_s     processor_pair_two,
  output cocr_pkg::cocr_pair_s     processor_pair_one,
  output cocr_pkg::cocr_pair_s     processor_pair_zero,
  // Single-ended clocks
  output logic [6:0]               slot_clock,
  output logic [2:0]               free_slot_clock,
  output logic                     mid_clock_0,
  output logic                     mid_or_video_clock_1,
  output logic                     mid_clock_5,
  output logic                     mid_clock_5_oe,
  output logic [2:0]               buffered_mid_clock,
  output logic                     display_48m_clock,
  output logic                     host_48m_clock,
  // Analog trims
  output logic [1:0]               buffered_delay_trim,
  output logic [1:0]               display_edge_rate,
  output logic [1:0]               host_edge_rate
);

  // ---------------------------------------------------------------
  // Bus sampling and conditions
  // ---------------------------------------------------------------
  logic scl_reg;
  logic sda_reg;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end else begin
      scl_reg <= smb_in.scl;
      sda_reg <= smb_in.sda;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  assign scl_rise   = smb_in.scl & ~scl_reg;
  assign scl_fall   = ~smb_in.scl & scl_reg;
  assign start_cond = smb_in.scl & scl_reg & sda_reg & ~smb_in.sda;
  assign stop_cond  = smb_in.scl & scl_reg & ~sda_reg & smb_in.sda;

  // ---------------------------------------------------------------
  // Block write receiver
  // ---------------------------------------------------------------
  cocr_pkg::cocr_state_e state_reg;
  logic [7:0]            shift_reg;
  logic [3:0]            bit_cnt_reg;
  logic                  ack_want_reg;
  logic                  ack_drive_reg;
  logic [5:0]            byte_idx_reg;
  logic [7:0]            remain_reg;
  logic                  byte_done;
  logic [7:0]            byte_now;

  // Byte completes on the eighth rising edge, MSB first
  assign byte_now  = {shift_reg[6:0], smb_in.sda};
  assign byte_done = scl_rise && !ack_drive_reg && bit_cnt_reg == 4'h7 &&
                     state_reg != cocr_pkg::ST_IDLE && state_reg != cocr_pkg::ST_IGNORE;

  always_ff @(posedge ref_clk) begin
    if (!resetn || start_cond || stop_cond) begin
      shift_reg   <= 8'h00;
      bit_cnt_reg <= 4'h0;
    end else if (scl_rise && !ack_drive_reg) begin
      shift_reg   <= byte_now;
      bit_cnt_reg <= (bit_cnt_reg == 4'h7) ? 4'h0 : bit_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_reg <= cocr_pkg::ST_IDLE;
    end else if (start_cond) begin
      state_reg <= cocr_pkg::ST_ADDR;
    end else if (stop_cond) begin
      state_reg <= cocr_pkg::ST_IDLE;
    end else if (byte_done) begin
      unique case (state_reg)
        cocr_pkg::ST_ADDR: begin
          state_reg <= (byte_now == `COCR_SLAVE_ADDR) ? cocr_pkg::ST_CMD : cocr_pkg::ST_IGNORE;
        end
        cocr_pkg::ST_CMD: begin
          state_reg <= (byte_now == `COCR_CMD_CODE) ? cocr_pkg::ST_COUNT : cocr_pkg::ST_IGNORE;
        end
        cocr_pkg::ST_COUNT: begin
          state_reg <= (byte_now >= `COCR_COUNT_MIN && byte_now <= `COCR_COUNT_MAX) ?
                       cocr_pkg::ST_DATA : cocr_pkg::ST_IGNORE;
        end
        cocr_pkg::ST_DATA: begin
          state_reg <= (remain_reg == 8'h01) ? cocr_pkg::ST_IGNORE : cocr_pkg::ST_DATA;
        end
        default: begin
          state_reg <= cocr_pkg::ST_IGNORE;
        end
      endcase
    end
  end

  // Acknowledge every accepted byte for one bit time
  always_ff @(posedge ref_clk) begin
    if (!resetn || start_cond || stop_cond) begin
      ack_want_reg  <= 1'b0;
      ack_drive_reg <= 1'b0;
    end else begin
      if (byte_done) begin
        unique case (state_reg)
          cocr_pkg::ST_ADDR:  ack_want_reg <= (byte_now == `COCR_SLAVE_ADDR);
          cocr_pkg::ST_CMD:   ack_want_reg <= (byte_now == `COCR_CMD_CODE);
          cocr_pkg::ST_COUNT: ack_want_reg <= (byte_now >= `COCR_COUNT_MIN && byte_now <= `COCR_COUNT_MAX);
          default:            ack_want_reg <= 1'b1;
        endcase
      end else if (scl_fall && ack_want_reg) begin
        ack_want_reg  <= 1'b0;
        ack_drive_reg <= 1'b1;
      end else if (scl_fall && ack_drive_reg) begin
        ack_drive_reg <= 1'b0;
      end
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = ack_drive_reg;

  // Data bytes land at ascending indexes from byte 0
  always_ff @(posedge ref_clk) begin
    if (!resetn || start_cond) begin
      byte_idx_reg <= 6'h00;
      remain_reg   <= 8'h00;
    end else if (byte_done && state_reg == cocr_pkg::ST_COUNT) begin
      remain_reg <= byte_now;
    end else if (byte_done && state_reg == cocr_pkg::ST_DATA) begin
      byte_idx_reg <= byte_idx_reg + 6'h01;
      remain_reg   <= remain_reg - 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  logic [7:0] cpu_pair_control_reg;
  logic [7:0] slot_clock_enables_reg;
  logic [7:0] usb_dot_free_slot_control_reg;
  logic [7:0] sixty_six_mhz_enables_reg;
  logic [7:0] delay_edge_rate_trim_reg;
  logic       wr_data;
  assign wr_data = byte_done && state_reg == cocr_pkg::ST_DATA;

  // Only writable bits take the byte, fixed bits hold their value
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cpu_pair_control_reg          <= `COCR_CPU_RST;
      slot_clock_enables_reg        <= `COCR_SLOT_RST;
      usb_dot_free_slot_control_reg <= `COCR_FREE_RST;
      sixty_six_mhz_enables_reg     <= `COCR_MID_RST;
      delay_edge_rate_trim_reg      <= `COCR_TRIM_RST;
    end else if (wr_data) begin
      unique case (byte_idx_reg)
        `COCR_IDX_CPU:  cpu_pair_control_reg          <= byte_now & `COCR_CPU_MASK;
        `COCR_IDX_SLOT: slot_clock_enables_reg        <= byte_now & `COCR_SLOT_MASK;
        `COCR_IDX_FREE: usb_dot_free_slot_control_reg <= byte_now & `COCR_FREE_MASK;
        `COCR_IDX_MID:  sixty_six_mhz_enables_reg     <= byte_now & `COCR_MID_MASK;
        `COCR_IDX_TRIM: delay_edge_rate_trim_reg      <= byte_now & `COCR_TRIM_MASK;
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Output run decisions
  // ---------------------------------------------------------------
  logic [2:0] cpu_en;
  logic [2:0] cpu_free;
  logic [2:0] cpu_run;
  logic [2:0] cpu_gated;
  logic       cpu_tri;
  logic [2:0] free_stop;
  logic [9:0] slot_run;
  logic [5:0] mid_run;
  logic [1:0] usb_run;

  assign cpu_en   = cpu_pair_control_reg[`COCR_CPU_EN_LSB +: 3];
  assign cpu_free = cpu_pair_control_reg[`COCR_CPU_FREE_LSB +: 3];
  assign cpu_tri  = cpu_pair_control_reg[`COCR_CPU_TRI_BIT];
  assign cpu_run  = cpu_en & {3{power_down_n}} & ({3{cpu_stop_n}} | cpu_free);

  assign free_stop = usb_dot_free_slot_control_reg[`COCR_FREE_STOP_LSB +: 3];
  assign slot_run  = {slot_clock_enables_reg[6:0] & {7{slot_stop_n}},
                      usb_dot_free_slot_control_reg[`COCR_FREE_EN_LSB +: 3] &
                      ({3{slot_stop_n}} | ~free_stop)} & {10{power_down_n}};
  assign mid_run   = {sixty_six_mhz_enables_reg[`COCR_MID0_EN_BIT],
                      sixty_six_mhz_enables_reg[`COCR_MID1_EN_BIT],
                      sixty_six_mhz_enables_reg[`COCR_MID5_EN_BIT] & mid5_is_output,
                      sixty_six_mhz_enables_reg[`COCR_BUF_EN_LSB +: 3]} & {6{power_down_n}};
  assign usb_run   = {usb_dot_free_slot_control_reg[`COCR_DISP_EN_BIT],
                      usb_dot_free_slot_control_reg[`COCR_HOST_EN_BIT]} & {2{power_down_n}};

  // ---------------------------------------------------------------
  // Gated clock outputs
  // ---------------------------------------------------------------
  logic [9:0] slot_gated;
  logic [5:0] mid_gated;
  logic [1:0] usb_gated;

  cocr_out_gate #(.W(3)) u_cpu_gate (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .src     ({3{cpu_src}}),
    .run     (cpu_run),
    .gated   (cpu_gated)
  );
  cocr_out_gate #(.W(10)) u_slot_gate (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .src     ({10{slot_src}}),
    .run     (slot_run),
    .gated   (slot_gated)
  );
  cocr_out_gate #(.W(6)) u_mid_gate (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .src     ({mid_src, mid_src, mid_src, {3{mid_in_src}}}),
    .run     (mid_run),
    .gated   (mid_gated)
  );
  cocr_out_gate #(.W(2)) u_usb_gate (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .src     ({2{usb_src}}),
    .run     (usb_run),
    .gated   (usb_gated)
  );

  assign slot_clock           = slot_gated[9:3];
  assign free_slot_clock      = slot_gated[2:0];
  assign mid_clock_0          = mid_gated[5];
  assign mid_or_video_clock_1 = mid_gated[4];
  assign mid_clock_5          = mid_gated[3];
  assign mid_clock_5_oe       = mid5_is_output;
  assign buffered_mid_clock   = mid_gated[2:0];
  assign display_48m_clock    = usb_gated[1];
  assign host_48m_clock       = usb_gated[0];

  assign buffered_delay_trim = delay_edge_rate_trim_reg[`COCR_DELAY_LSB +: 2];
  assign display_edge_rate   = delay_edge_rate_trim_reg[`COCR_DISP_RATE_LSB +: 2];
  assign host_edge_rate      = delay_edge_rate_trim_reg[`COCR_HOST_RATE_LSB +: 2];

  // ---------------------------------------------------------------
  // Processor pair drive
  // ---------------------------------------------------------------
  function automatic cocr_pkg::cocr_pair_s pair_drive(input logic en, input logic run, input logic gated);
    cocr_pkg::cocr_pair_s p;
    p.true_clk = gated;
    p.comp_clk = ~gated;
    p.true_oe  = en;
    p.comp_oe  = en & run;
    if (!power_down_n) begin
      p.true_clk = 1'b1;
      p.comp_clk = 1'b0;
      p.true_oe  = en & ~cpu_tri;
      p.comp_oe  = 1'b0;
    end else if (en && !run) begin
      p.true_clk = 1'b1;
    end
    return p;
  endfunction : pair_drive

  // Process form so that power down and three-state bits read inside the function re-evaluate
  always_comb begin
    processor_pair_two  = pair_drive(cpu_en[2], cpu_run[2], cpu_gated[2]);
    processor_pair_one  = pair_drive(cpu_en[1], cpu_run[1], cpu_gated[1]);
    processor_pair_zero = pair_drive(cpu_en[0], cpu_run[0], cpu_gated[0]);
  end

endmodule : cocr_top

// *** hw/cocr_regs.svh ***
// Register layout, reset values and bus constants of the clock output control bank
// Functional notes
// - Byte1 bit6 three-states processor pairs in power down
// - Byte1 bits5:3 set processor pairs free running
// - Byte1 bits2:0 enable processor pairs, reset 1
// - Byte2 bits6:0 enable slot clocks; bit7 reads 0
// - Byte3 enables 48 MHz outputs and free slots
// - Byte3 bits5:3 let slot-stop stop free slots
// - Byte4 bits5:3 enable mid clocks; bits7:6 zero
// - Byte4 bits2:0 enable buffered mid clocks
// - Byte5 bits5:4 trim buffered mid delay
// - Byte5 edge rate fields; bits7:6 read 0
// - Bytes written ascending from byte 0, MSB first
// - Address D2h, command 00h, then byte count
`ifndef COCR_REGS_SVH
`define COCR_REGS_SVH

// ---------------------------------------------------------------
// Bus framing
// ---------------------------------------------------------------
`define COCR_SLAVE_ADDR     8'hd2
`define COCR_CMD_CODE       8'h00
`define COCR_COUNT_MIN      8'h01
`define COCR_COUNT_MAX      8'h20

// ---------------------------------------------------------------
// Byte indexes within a block write
// ---------------------------------------------------------------
`define COCR_IDX_CPU        6'h01
`define COCR_IDX_SLOT       6'h02
`define COCR_IDX_FREE       6'h03
`define COCR_IDX_MID        6'h04
`define COCR_IDX_TRIM       6'h05

// ---------------------------------------------------------------
// Reset values and writable masks
// ---------------------------------------------------------------
`define COCR_CPU_RST        8'h07
`define COCR_CPU_MASK       8'h7f
`define COCR_SLOT_RST       8'h7f
`define COCR_SLOT_MASK      8'h7f
`define COCR_FREE_RST       8'hc7
`define COCR_FREE_MASK      8'hff
`define COCR_MID_RST        8'h3f
`define COCR_MID_MASK       8'h3f
`define COCR_TRIM_RST       8'h00
`define COCR_TRIM_MASK      8'h3f

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define COCR_CPU_TRI_BIT    6
`define COCR_CPU_FREE_LSB   3
`define COCR_CPU_EN_LSB     0
`define COCR_DISP_EN_BIT    7
`define COCR_HOST_EN_BIT    6
`define COCR_FREE_STOP_LSB  3
`define COCR_FREE_EN_LSB    0
`define COCR_MID0_EN_BIT    5
`define COCR_MID1_EN_BIT    4
`define COCR_MID5_EN_BIT    3
`define COCR_BUF_EN_LSB     0
`define COCR_DELAY_LSB      4
`define COCR_DISP_RATE_LSB  2
`define COCR_HOST_RATE_LSB  0

`endif

// *** hw/cocr_pkg.sv ***
// Types shared by the clock output control bank
package cocr_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_COUNT,
    ST_DATA,
    ST_IGNORE
  } cocr_state_e;

  typedef struct packed {
    logic scl;
    logic sda;
  } cocr_smb_s;

  typedef struct packed {
    logic true_clk;
    logic true_oe;
    logic comp_clk;
    logic comp_oe;
  } cocr_pair_s;

endpackage : cocr_pkg

// *** hw/cocr_out_gate.sv ***
// Glitch-free stop-low gate for a group of single-ended clocks
`timescale 1ns/1ps
module cocr_out_gate #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         resetn,
  // Source clocks and run requests
  input  wire logic [W-1:0] src,
  input  wire logic [W-1:0] run,
  // Gated outputs
  output logic      [W-1:0] gated
);

  logic [W-1:0] run_reg;
  logic [W-1:0] gated_reg;

  // Run state only changes while the source is low
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      run_reg <= '0;
    end else begin
      run_reg <= (run_reg & src) | (run & ~src);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      gated_reg <= '0;
    end else begin
      gated_reg <= src & run_reg;
    end
  end

  assign gated = gated_reg;

endmodule : cocr_out_gate

// *** verif/cocr_host_model.sv ***
// Serial bus host model that issues block writes to the bank
`timescale 1ns/1ps
module cocr_host_model (
  // Clock
  input  wire logic           ref_clk,
  // Device side of the data pin
  input  wire logic           sda_oe,
  input  wire logic           sda_out,
  // Wired bus levels
  output cocr_pkg::cocr_smb_s smb
);
  logic scl_drv = 1'b1;
  logic sda_drv = 1'b1;

  // Pull-up on both lines; data low when either party pulls it low
  always_comb begin
    smb.scl = scl_drv;
    smb.sda = sda_drv & ~(sda_oe & ~sda_out);
  end

  // Every level is held four cycles, above the two the device needs
  task automatic hold();
    repeat (4) @(posedge ref_clk);
  endtask : hold

  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_drv <= b[i];
      hold();
      scl_drv <= 1'b1;
      hold();
      scl_drv <= 1'b0;
      hold();
    end
    sda_drv <= 1'b1;
    hold();
    scl_drv <= 1'b1;
    hold();
    ack = ~smb.sda;
    scl_drv <= 1'b0;
    hold();
  endtask : send_byte

  task automatic block_write(input logic [7:0] adr, input logic [7:0] cmd, input logic [7:0] cnt,
                             input logic [7:0] d [8], input int nb, output logic [2:0] acks);
    logic a;
    sda_drv <= 1'b0;
    hold();
    scl_drv <= 1'b0;
    hold();
    send_byte(adr, acks[2]);
    send_byte(cmd, acks[1]);
    send_byte(cnt, acks[0]);
    for (int k = 0; k < nb; k++) send_byte(d[k], a);
    sda_drv <= 1'b0;
    hold();
    scl_drv <= 1'b1;
    hold();
    sda_drv <= 1'b1;
    hold();
  endtask : block_write
endmodule : cocr_host_model

// *** verif/cocr_top_sva.sv ***
// Port checker for the clock output control bank
`timescale 1ns/1ps
module cocr_top_sva (
  // Clock and reset
  input wire logic                 ref_clk,
  input wire logic                 resetn,
  // Bus and control pins
  input wire cocr_pkg::cocr_smb_s  smb_in,
  input wire logic                 sda_oe,
  input wire logic                 power_down_n,
  input wire logic                 cpu_stop_n,
  input wire logic                 slot_stop_n,
  input wire logic                 slot_src,
  // Outputs
  input wire cocr_pkg::cocr_pair_s processor_pair_zero,
  input wire logic [6:0]           slot_clock,
  input wire logic [2:0]           free_slot_clock,
  input wire logic                 display_48m_clock,
  input wire logic [1:0]           buffered_delay_trim,
  input wire logic [1:0]           display_edge_rate,
  input wire logic [1:0]           host_edge_rate
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_pd_outputs_low: assert property (!power_down_n [*5] |-> slot_clock == 7'h00 && free_slot_clock == 3'h0)
    else $error("Clock output active in power down");
  a_pd_comp_off: assert property (!power_down_n [*3] |-> !processor_pair_zero.comp_oe)
    else $error("Pair complement driven in power down");
  a_pair_inverse: assert property (processor_pair_zero.comp_oe |-> processor_pair_zero.true_oe &&
    processor_pair_zero.comp_clk != processor_pair_zero.true_clk)
    else $error("Pair halves not complementary");
  a_stop_true_high: assert property (processor_pair_zero.true_oe && !processor_pair_zero.comp_oe |->
    processor_pair_zero.true_clk)
    else $error("Stopped pair not parked high");
  a_run_no_stop: assert property ((power_down_n && cpu_stop_n) [*3] |->
    !(processor_pair_zero.true_oe && !processor_pair_zero.comp_oe))
    else $error("Pair stopped without stop request");
  a_slot_stop_low: assert property ((power_down_n && !slot_stop_n) [*5] |-> slot_clock == 7'h00)
    else $error("Slot clock runs during slot stop");
  a_gate_source: assert property (slot_clock != 7'h00 |-> $past(slot_src))
    else $error("Slot clock high without source");
  a_ack_in_low: assert property ($rose(sda_oe) |-> !smb_in.scl)
    else $error("Acknowledge begins with clock high");
  a_ack_end_low: assert property ($fell(sda_oe) |-> !smb_in.scl)
    else $error("Acknowledge ends with clock high");
  a_trim_on_bit: assert property (!$stable({buffered_delay_trim, display_edge_rate, host_edge_rate}) |->
    smb_in.scl)
    else $error("Trim changed outside a bit");

  c_ack: cover property ($rose(sda_oe));
  c_pair_stopped: cover property (processor_pair_zero.true_oe && !processor_pair_zero.comp_oe);
  c_trim_write: cover property (!$stable(host_edge_rate));
endmodule : cocr_top_sva

bind cocr_top cocr_top_sva cocr_top_sva_inst (
  .ref_clk(ref_clk), .resetn(resetn), .smb_in(smb_in), .sda_oe(sda_oe), .power_down_n(power_down_n),
  .cpu_stop_n(cpu_stop_n), .slot_stop_n(slot_stop_n), .slot_src(slot_src),
  .processor_pair_zero(processor_pair_zero), .slot_clock(slot_clock), .free_slot_clock(free_slot_clock),
  .display_48m_clock(display_48m_clock), .buffered_delay_trim(buffered_delay_trim),
  .display_edge_rate(display_edge_rate), .host_edge_rate(host_edge_rate)
);

// *** verif/clock_output_control_regs_tb_top.sv ***
// Self-checking bench for the clock output control bank
`timescale 1ns/1ps
`include "cocr_regs.svh"
module clock_output_control_regs_tb_top;
  logic                 ref_clk;
  logic                 resetn = 1'b0;
  logic                 pd_n   = 1'b1;
  logic                 cs_n   = 1'b1;
  logic                 ss_n   = 1'b1;
  logic                 m5     = 1'b1;
  logic [3:0]           sc     = 4'h0;
  cocr_pkg::cocr_smb_s  smb;
  cocr_pkg::cocr_pair_s p2, p1, p0;
  logic                 sda_out, sda_oe, mc0, mc1, mc5, dc, hc, m5oe;
  logic [6:0]           slot;
  logic [2:0]           fs, bm;
  logic [1:0]           dt, de, he;
  logic [7:0]           rm [6];
  logic [29:0]          exp_q [$];
  int                   num_errors   = 0;
  int                   total_checks = 0;
  event                 obs_ev;
  localparam logic [7:0]  msk [6] = '{8'h00, `COCR_CPU_MASK, `COCR_SLOT_MASK, `COCR_FREE_MASK,
                                      `COCR_MID_MASK, `COCR_TRIM_MASK};
  localparam logic [31:0] bad [4] = '{32'hd3000500, 32'hd2010504, 32'hd2000006, 32'hd2002106};

  cocr_top cocr_top_inst (.ref_clk(ref_clk), .resetn(resetn), .smb_in(smb), .sda_out(sda_out),
    .sda_oe(sda_oe), .power_down_n(pd_n), .cpu_stop_n(cs_n), .slot_stop_n(ss_n), .mid5_is_output(m5),
    .cpu_src(sc[0]), .slot_src(sc[1]), .mid_src(sc[1]), .mid_in_src(sc[1]), .usb_src(sc[1]),
    .processor_pair_two(p2), .processor_pair_one(p1), .processor_pair_zero(p0), .slot_clock(slot),
    .free_slot_clock(fs), .mid_clock_0(mc0), .mid_or_video_clock_1(mc1), .mid_clock_5(mc5),
    .mid_clock_5_oe(m5oe), .buffered_mid_clock(bm), .display_48m_clock(dc), .host_48m_clock(hc),
    .buffered_delay_trim(dt), .display_edge_rate(de), .host_edge_rate(he));
  cocr_host_model cocr_host_model_inst (.ref_clk(ref_clk), .sda_oe(sda_oe), .sda_out(sda_out), .smb(smb));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) sc <= sc + 4'h1;

  task automatic check(input logic [29:0] got, input logic [29:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("Compared %0d, mismatched %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run

  function automatic logic [29:0] expect_of();
    logic [2:0]  te;
    logic [2:0]  ce;
    logic [17:0] se;
    te = pd_n ? rm[1][2:0] : rm[1][2:0] & {3{~rm[1][6]}};
    ce = pd_n ? rm[1][2:0] & (cs_n ? 3'h7 : rm[1][5:3]) : 3'h0;
    se = {rm[2][6:0] & {7{ss_n}}, rm[3][2:0] & (ss_n ? 3'h7 : ~rm[3][5:3]),
          rm[4][5:3] & {2'h3, m5}, rm[4][2:0], rm[3][7:6]};
    return {rm[5][5:0], te, ce, pd_n ? se : 18'h0};
  endfunction : expect_of

  task automatic observe();
    @(posedge ref_clk);
    exp_q.push_back(expect_of());
    -> obs_ev;
    repeat (30) @(posedge ref_clk);
  endtask : observe

  task automatic do_reset();
    resetn <= 1'b0;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    rm = '{8'h00, `COCR_CPU_RST, `COCR_SLOT_RST, `COCR_FREE_RST, `COCR_MID_RST, `COCR_TRIM_RST};
    observe();
  endtask : do_reset

  initial begin : monitor
    logic [29:0] seen;
    forever begin
      @(obs_ev);
      repeat (8) @(posedge ref_clk);
      seen = 30'h0;
      repeat (16) begin
        @(negedge ref_clk);
        seen = seen | {dt, de, he, p2.true_oe, p1.true_oe, p0.true_oe, p2.comp_oe, p1.comp_oe, p0.comp_oe,
                       slot, fs, mc0, mc1, mc5, bm, dc, hc};
      end
      check(seen, exp_q.pop_front());
    end
  end

  initial begin : watchdog
    repeat (100000) @(posedge ref_clk);
    num_errors++;
    complete_run();
  end

  initial begin : main
    logic [7:0] d [8];
    logic [2:0] ack;
    int         n;
    void'($urandom(2766));
    do_reset();
    for (int t = 7; t >= 0; t--) begin
      n = 1 + $urandom_range(7);
      for (int k = 0; k < 8; k++) d[k] = 8'($urandom());
      d[4][3] = d[4][3] | ~t[0] | ~m5;
      cocr_host_model_inst.block_write(`COCR_SLAVE_ADDR, `COCR_CMD_CODE, 8'(n), d, n, ack);
      check({27'h0, ack}, 30'h7);
      for (int k = 1; k < 6; k++) if (k < n) rm[k] = d[k] & msk[k];
      {pd_n, cs_n, ss_n} <= 3'(t);
      m5 <= t[0];
      observe();
      check({29'h0, m5oe}, {29'h0, m5});
      {pd_n, cs_n, ss_n} <= 3'h7;
    end
    foreach (bad[i]) begin
      cocr_host_model_inst.block_write(bad[i][31:24], bad[i][23:16], bad[i][15:8], d, 6, ack);
      check({27'h0, ack}, {27'h0, bad[i][2:0]});
      observe();
    end
    do_reset();
    complete_run();
  end
endmodule : clock_output_control_regs_tb_top
